//--- bench/crf_core_props.sv
// crf_core_props: port-level timing checks for the core register file.
// assumes it is bound into crf_core; one clock, synchronous reset.
`timescale 1ns/1ns
module crf_core_props #(
  parameter int DW = crf_pkg::DATA_W,
  parameter int PW = crf_pkg::PRIO_W
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              clk_en,
  // access port
  input wire crf_pkg::crf_acc_t acc,
  input wire logic [DW-1:0]     reg_rdata,
  input wire logic              access_fault,
  // events
  input wire logic              call_strobe,
  input wire logic [DW-1:0]     call_return,
  input wire logic              flags_we,
  input wire logic [4:0]        flags_in,
  input wire logic              exc_enter,
  input wire logic [PW-1:0]     exc_number,
  input wire logic              exc_return,
  // gate and views
  input wire crf_pkg::crf_req_t req,
  input wire logic              req_allowed,
  input wire logic [DW-1:0]     instruction_pointer_out,
  input wire logic [DW-1:0]     stack_pointer_out,
  input wire logic [DW-1:0]     status_word_out,
  input wire logic              handler_mode,
  input wire logic              user_level
);
  import crf_pkg::*;
  logic [1:0] up_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // enabled edges since reset, saturating
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      up_cnt <= 2'h0;
    else if (clk_en && up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;
  end
  sequence touch_s;
    clk_en && (acc.wr || acc.rd);
  endsequence
  sequence refused_s;
    ##1 access_fault && reg_rdata == '0;
  endsequence
  // views lag the state by one more flop, so both edges must be enabled
  sequence enter_s;
    clk_en && exc_enter ##1 clk_en;
  endsequence
  sequence leave_s;
    clk_en && exc_return && !exc_enter ##1 clk_en;
  endsequence
  idle_rdata_a: assert property (clk_en && !acc.rd |=> reg_rdata == '0)
    else $error("read data not idle");
  status_bit_a: assert property (up_cnt == 2'h3 |-> status_word_out[TBIT])
    else $error("status bit 24 low");
  bit_clear_a: assert property (touch_s ##0 (acc.wr && !acc.wdata[TBIT] &&
    (acc.addr == IDX_STATUS || acc.addr == IDX_EXEC_VIEW)) |-> refused_s) else $error("bit 24 clear kept");
  narrow_hi_a: assert property (touch_s ##0 (acc.narrow && !acc.narrow_hi_ok &&
    acc.addr >= IDX_HIGH_FIRST && acc.addr <= IDX_GPR_LAST) |-> refused_s) else $error("narrow access kept");
  user_special_a: assert property (touch_s ##0 (acc.addr >= IDX_STATUS &&
    acc.addr != IDX_APP_VIEW) ##1 user_level |-> access_fault && reg_rdata == '0) else $error("user access kept");
  stack_align_a: assert property (stack_pointer_out[1:0] == 2'h0)
    else $error("stack pointer unaligned");
  ip_align_a: assert property (!instruction_pointer_out[0])
    else $error("instruction pointer odd");
  exc_entry_a: assert property (enter_s |=>
    handler_mode && status_word_out[INT_HI:INT_LO] == $past(exc_number, 2)) else $error("entry wrong");
  exc_leave_a: assert property (leave_s |=>
    !handler_mode && status_word_out[INT_HI:INT_LO] == '0) else $error("return wrong");
  nmi_pass_a: assert property (clk_en && req.valid && req.nmi |=> req_allowed)
    else $error("nmi blocked");
endmodule

bind crf_core crf_core_props #(.DW(DW), .PW(PW)) i_crf_core_props (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .acc(acc), .reg_rdata(reg_rdata),
  .access_fault(access_fault), .call_strobe(call_strobe), .call_return(call_return),
  .flags_we(flags_we), .flags_in(flags_in), .exc_enter(exc_enter), .exc_number(exc_number),
  .exc_return(exc_return), .req(req), .req_allowed(req_allowed),
  .instruction_pointer_out(instruction_pointer_out), .stack_pointer_out(stack_pointer_out),
  .status_word_out(status_word_out), .handler_mode(handler_mode), .user_level(user_level));

//--- bench/crf_core_tb_top.sv
// crf_core_tb_top: directed bench for the core register file.
// assumes crf_core with its checker bound; one 20 MHz clock.
`timescale 1ns/1ns
module crf_core_tb_top;
  import crf_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  crf_acc_t    acc = '0;
  logic [31:0] reg_rdata;
  logic        access_fault;
  logic        call_strobe = 1'b0;
  logic [31:0] call_return = '0;
  logic        flags_we = 1'b0;
  logic [4:0]  flags_in = '0;
  logic        exc_enter = 1'b0;
  logic [8:0]  exc_number = '0;
  logic        exc_return = 1'b0;
  crf_req_t    req = '0;
  logic        req_allowed;
  logic [31:0] ip_out;
  logic [31:0] sp_out;
  logic [31:0] sw_out;
  logic        handler_mode;
  logic        user_level;
  int          fails = 0;
  int          samples_checked = 0;

  crf_core i_crf_core (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .acc(acc), .reg_rdata(reg_rdata),
    .access_fault(access_fault), .call_strobe(call_strobe), .call_return(call_return), .flags_we(flags_we),
    .flags_in(flags_in), .exc_enter(exc_enter), .exc_number(exc_number), .exc_return(exc_return),
    .req(req), .req_allowed(req_allowed), .instruction_pointer_out(ip_out), .stack_pointer_out(sp_out),
    .status_word_out(sw_out), .handler_mode(handler_mode), .user_level(user_level));

  always #25 sys_clk = ~sys_clk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one access cycle, then data and fault in the following cycle
  task automatic op(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [31:0] e,
                    input logic f);
    @(posedge sys_clk);
    acc.wr <= w;
    acc.rd <= !w;
    acc.addr <= a;
    acc.wdata <= d;
    @(posedge sys_clk);
    acc.wr <= 1'b0;
    acc.rd <= 1'b0;
    #1;
    check({access_fault, reg_rdata}, {f, e});
  endtask

  task automatic ev(input logic en, input logic ret);
    @(posedge sys_clk);
    exc_enter <= en;
    exc_return <= ret;
    @(posedge sys_clk);
    exc_enter <= 1'b0;
    exc_return <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic gate(input logic v, input logic [8:0] p, input logic n, input logic h, input logic e);
    @(posedge sys_clk);
    req <= {v, p, n, h};
    @(posedge sys_clk);
    req <= '0;
    #1;
    check({32'h0, req_allowed}, {32'h0, e});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check({1'b0, sw_out}, 33'h0_0100_0000);
    check({handler_mode, user_level}, 33'h0);
    for (int i = 20; i < 24; i++)
      op(0, 5'(i), 32'h0, 32'h0, 1'b0);
    $display("reset test done");
    for (int i = 0; i < 13; i++)
      op(1, 5'(i), 32'hA5A5_0000 + i, 32'h0, 1'b0);
    for (int i = 0; i < 13; i++)
      op(0, 5'(i), 32'h0, 32'hA5A5_0000 + i, 1'b0);
    op(1, IDX_IPTR, 32'h1234_5677, 32'h0, 1'b0);
    op(0, IDX_IPTR, 32'h0, 32'h1234_5676, 1'b0);
    check({1'b0, ip_out}, 33'h0_1234_5676);
    acc.narrow <= 1'b1;
    op(1, 5'h09, 32'h0, 32'h0, 1'b1);
    op(0, 5'h07, 32'h0, 32'hA5A5_0007, 1'b0);
    acc.narrow_hi_ok <= 1'b1;
    op(0, 5'h09, 32'h0, 32'hA5A5_0009, 1'b0);
    acc.narrow <= 1'b0;
    acc.narrow_hi_ok <= 1'b0;
    op(0, 5'h1A, 32'h0, 32'h0, 1'b1);
    $display("register test done");
    op(1, IDX_APP_VIEW, 32'hF800_0000, 32'h0, 1'b0);
    op(1, IDX_EXEC_VIEW, 32'h0700_FC00, 32'h0, 1'b0);
    op(1, IDX_STATUS, 32'h0, 32'h0, 1'b1);
    op(0, IDX_STATUS, 32'h0, 32'hFF00_FC00, 1'b0);
    op(0, IDX_EXEC_VIEW, 32'h0, 32'h0700_FC00, 1'b0);
    @(posedge sys_clk);
    flags_we <= 1'b1;
    flags_in <= 5'h0A;
    call_strobe <= 1'b1;
    call_return <= 32'hABCD_0000;
    @(posedge sys_clk);
    flags_we <= 1'b0;
    call_strobe <= 1'b0;
    op(0, IDX_APP_VIEW, 32'h0, 32'h5000_0000, 1'b0);
    op(0, IDX_RETURN, 32'h0, 32'hABCD_0000, 1'b0);
    $display("status test done");
    op(1, IDX_MAIN_STACK, 32'h3000_0003, 32'h0, 1'b0);
    op(1, IDX_PROC_STACK, 32'h2000_0006, 32'h0, 1'b0);
    op(0, IDX_STACK, 32'h0, 32'h3000_0000, 1'b0);
    op(1, IDX_MODE_CTRL, 32'h2, 32'h0, 1'b0);
    op(0, IDX_STACK, 32'h0, 32'h2000_0004, 1'b0);
    exc_number <= 9'h1FF;
    ev(1'b1, 1'b0);
    check({handler_mode, sw_out}, {1'b1, 32'h5700_FDFF});
    check({1'b0, sp_out}, 33'h0_3000_0000);
    op(1, IDX_MODE_CTRL, 32'h3, 32'h0, 1'b0);
    op(0, IDX_MODE_CTRL, 32'h0, 32'h1, 1'b0);
    check({handler_mode, user_level}, 33'h2);
    ev(1'b0, 1'b1);
    check({handler_mode, user_level, sw_out[8:0]}, 33'h200);
    op(0, IDX_PRI_MASK, 32'h0, 32'h0, 1'b1);
    op(0, IDX_APP_VIEW, 32'h0, 32'h5000_0000, 1'b0);
    ev(1'b1, 1'b0);
    op(1, IDX_MODE_CTRL, 32'h0, 32'h0, 1'b0);
    ev(1'b0, 1'b1);
    $display("mode test done");
    gate(1'b0, 9'h0, 1'b1, 1'b0, 1'b0);
    op(1, IDX_PRI_MASK, 32'h1, 32'h0, 1'b0);
    gate(1'b1, 9'h5, 1'b0, 1'b0, 1'b0);
    gate(1'b1, 9'h5, 1'b0, 1'b1, 1'b1);
    gate(1'b1, 9'h5, 1'b1, 1'b0, 1'b1);
    op(1, IDX_PRI_MASK, 32'h0, 32'h0, 1'b0);
    op(1, IDX_FAULT_MASK, 32'h1, 32'h0, 1'b0);
    gate(1'b1, 9'h5, 1'b0, 1'b1, 1'b0);
    gate(1'b1, 9'h5, 1'b1, 1'b0, 1'b1);
    op(1, IDX_FAULT_MASK, 32'h0, 32'h0, 1'b0);
    op(1, IDX_BASE_PRI, 32'hFFFF_FFFF, 32'h0, 1'b0);
    op(0, IDX_BASE_PRI, 32'h0, 32'h1FF, 1'b0);
    gate(1'b1, 9'h1FF, 1'b0, 1'b0, 1'b0);
    gate(1'b1, 9'h1FE, 1'b0, 1'b0, 1'b1);
    op(1, IDX_BASE_PRI, 32'h0, 32'h0, 1'b0);
    gate(1'b1, 9'h1FF, 1'b0, 1'b0, 1'b1);
    $display("mask test done");
    op(0, 5'h03, 32'h0, 32'hA5A5_0003, 1'b0);
    // frozen: read data holds, no fault, no write lands
    clk_en <= 1'b0;
    op(1, IDX_STATUS, 32'h0, 32'hA5A5_0003, 1'b0);
    op(1, 5'h03, 32'h0, 32'hA5A5_0003, 1'b0);
    clk_en <= 1'b1;
    op(0, 5'h03, 32'h0, 32'hA5A5_0003, 1'b0);
    $display("enable test done");
    print_verdict();
  end
endmodule

//--- verilog/crf_core.sv
// crf_core: core register set with banked stack, status views and masks.
// assumes the execution unit drives the access port; one access per cycle.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
module crf_core #(
  parameter int DW = crf_pkg::DATA_W,
  parameter int PW = crf_pkg::PRIO_W
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // register access port
  input  wire crf_pkg::crf_acc_t acc,
  output logic [DW-1:0]          reg_rdata,
  output logic                   access_fault,
  // execution events
  input  wire logic              call_strobe,
  input  wire logic [DW-1:0]     call_return,
  input  wire logic              flags_we,
  input  wire logic [4:0]        flags_in,
  input  wire logic              exc_enter,
  input  wire logic [PW-1:0]     exc_number,
  input  wire logic              exc_return,
  // exception gating
  input  wire crf_pkg::crf_req_t req,
  output logic                   req_allowed,
  // state views
  output logic [DW-1:0]          instruction_pointer_out,
  output logic [DW-1:0]          stack_pointer_out,
  output logic [DW-1:0]          status_word_out,
  output logic                   handler_mode,
  output logic                   user_level
);
  import crf_pkg::*;

  logic [DW-1:0]     gpr [0:NUM_GPR-1];
  logic [DW-1:0]     main_stack_pointer;
  logic [DW-1:0]     process_stack_pointer;
  logic [DW-1:0]     return_address_register;
  logic [DW-1:0]     instruction_pointer;
  logic [4:0]        application_status_view;
  logic [PW-1:0]     interrupt_status_view;
  logic [5:0]        exec_view_a;
  logic [1:0]        exec_view_b;
  logic              priority_mask_bit;
  logic              fault_mask_bit;
  logic [PW-1:0]     base_priority_threshold;
  logic [1:0]        mode_control;
  logic              in_handler;

  logic              is_user;
  logic              use_process_stack;
  logic              special;
  logic              refused;
  logic              tbit_clear;
  logic              wr_ok;
  logic [DW-1:0]     status_word;
  logic [DW-1:0]     next_rdata;
  logic              next_allowed;

  // privilege and stack selection
  always_comb
  begin
    is_user = !in_handler && mode_control[CTRL_USER];
    use_process_stack = !in_handler && mode_control[CTRL_ALT_STACK];
  end

  // combined status word with fixed bit 24
  always_comb
  begin
    status_word = '0;
    status_word[APP_HI:APP_LO] = application_status_view;
    status_word[INT_HI:INT_LO] = interrupt_status_view;
    status_word[EXA_HI:EXA_LO] = exec_view_a;
    status_word[EXB_HI:EXB_LO] = exec_view_b;
    status_word[TBIT] = 1'b1;
  end

  // access legality
  always_comb
  begin
    special = (acc.addr >= IDX_STATUS) && (acc.addr != IDX_APP_VIEW);
    refused = 1'b0;
    if (acc.addr > IDX_PROC_STACK)
      refused = 1'b1;
    else if (is_user && special)
      refused = 1'b1;
    else if (acc.narrow && !acc.narrow_hi_ok && acc.addr >= IDX_HIGH_FIRST && acc.addr <= IDX_GPR_LAST)
      refused = 1'b1;
    tbit_clear = acc.wr && !refused && !acc.wdata[TBIT]
      && (acc.addr == IDX_STATUS || acc.addr == IDX_EXEC_VIEW);
    wr_ok = acc.wr && !refused && !tbit_clear;
  end

  // general registers 0-12, low ones never refused
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GPR; gi++)
    begin : g_gpr
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          gpr[gi] <= RST_WORD;
        else if (clk_en && wr_ok && acc.addr == ADDR_W'(gi))
          gpr[gi] <= acc.wdata;
      end
    end
  endgenerate

  // banked stack pointers, word aligned on store
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      main_stack_pointer <= RST_WORD;
      process_stack_pointer <= RST_WORD;
    end
    else if (clk_en && wr_ok)
    begin
      if ((acc.addr == IDX_STACK && !use_process_stack) || acc.addr == IDX_MAIN_STACK)
        main_stack_pointer <= {acc.wdata[DW-1:SP_ALIGN_BITS], {SP_ALIGN_BITS{1'b0}}};
      if ((acc.addr == IDX_STACK && use_process_stack) || acc.addr == IDX_PROC_STACK)
        process_stack_pointer <= {acc.wdata[DW-1:SP_ALIGN_BITS], {SP_ALIGN_BITS{1'b0}}};
    end
  end

  // return address: call wins over a port write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      return_address_register <= RST_WORD;
    else if (clk_en)
    begin
      if (call_strobe)
        return_address_register <= call_return;
      else if (wr_ok && acc.addr == IDX_RETURN)
        return_address_register <= acc.wdata;
    end
  end

  // instruction pointer, halfword aligned
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      instruction_pointer <= RST_WORD;
    else if (clk_en && wr_ok && acc.addr == IDX_IPTR)
      instruction_pointer <= {acc.wdata[DW-1:1], 1'b0};
  end

  // application view: flag update wins over a port write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      application_status_view <= '0;
    else if (clk_en)
    begin
      if (flags_we)
        application_status_view <= flags_in;
      else if (wr_ok && (acc.addr == IDX_STATUS || acc.addr == IDX_APP_VIEW))
        application_status_view <= acc.wdata[APP_HI:APP_LO];
    end
  end

  // interrupt view and handler mode follow exception events
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      interrupt_status_view <= '0;
      in_handler <= 1'b0;
    end
    else if (clk_en)
    begin
      if (exc_enter)
      begin
        interrupt_status_view <= exc_number;
        in_handler <= 1'b1;
      end
      else if (exc_return)
      begin
        interrupt_status_view <= '0;
        in_handler <= 1'b0;
      end
      else if (wr_ok && (acc.addr == IDX_STATUS || acc.addr == IDX_INT_VIEW))
        interrupt_status_view <= acc.wdata[INT_HI:INT_LO];
    end
  end

  // execution view fields
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      exec_view_a <= '0;
      exec_view_b <= '0;
    end
    else if (clk_en && wr_ok && (acc.addr == IDX_STATUS || acc.addr == IDX_EXEC_VIEW))
    begin
      exec_view_a <= acc.wdata[EXA_HI:EXA_LO];
      exec_view_b <= acc.wdata[EXB_HI:EXB_LO];
    end
  end

  // mask registers and mode control
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      priority_mask_bit <= 1'b0;
      fault_mask_bit <= 1'b0;
      base_priority_threshold <= RST_BASE_PRIORITY_THRESHOLD;
      mode_control <= RST_CTRL;
    end
    else if (clk_en && wr_ok)
    begin
      case (acc.addr)
        IDX_PRI_MASK:   priority_mask_bit <= acc.wdata[0];
        IDX_FAULT_MASK: fault_mask_bit <= acc.wdata[0];
        IDX_BASE_PRI:   base_priority_threshold <= acc.wdata[PW-1:0];
        IDX_MODE_CTRL:
        begin
          mode_control[CTRL_USER] <= acc.wdata[CTRL_USER];
          mode_control[CTRL_ALT_STACK] <= acc.wdata[CTRL_ALT_STACK] && !in_handler;
        end
        default: ;
      endcase
    end
  end

  // read mux
  always_comb
  begin
    next_rdata = '0;
    if (acc.rd && !refused)
    begin
      if (acc.addr <= IDX_GPR_LAST)
        next_rdata = gpr[acc.addr[3:0]];
      else
      begin
        case (acc.addr)
          IDX_STACK:
            next_rdata = use_process_stack ? process_stack_pointer : main_stack_pointer;
          IDX_RETURN:     next_rdata = return_address_register;
          IDX_IPTR:       next_rdata = instruction_pointer;
          IDX_STATUS:     next_rdata = status_word;
          IDX_APP_VIEW:
            next_rdata = {application_status_view, {APP_LO{1'b0}}};
          IDX_INT_VIEW:   next_rdata = DW'(interrupt_status_view);
          IDX_EXEC_VIEW:
          begin
            next_rdata[EXA_HI:EXA_LO] = exec_view_a;
            next_rdata[EXB_HI:EXB_LO] = exec_view_b;
            next_rdata[TBIT] = 1'b1;
          end
          IDX_PRI_MASK:   next_rdata = DW'(priority_mask_bit);
          IDX_FAULT_MASK: next_rdata = DW'(fault_mask_bit);
          IDX_BASE_PRI:   next_rdata = DW'(base_priority_threshold);
          IDX_MODE_CTRL:  next_rdata = DW'(mode_control);
          IDX_MAIN_STACK: next_rdata = main_stack_pointer;
          IDX_PROC_STACK: next_rdata = process_stack_pointer;
          default:        next_rdata = '0;
        endcase
      end
      next_rdata[SP_ALIGN_BITS-1:0] = (acc.addr == IDX_STACK || acc.addr == IDX_MAIN_STACK
        || acc.addr == IDX_PROC_STACK) ? '0 : next_rdata[SP_ALIGN_BITS-1:0];
      next_rdata[0] = (acc.addr == IDX_IPTR) ? 1'b0 : next_rdata[0];
    end
  end

  // read data and fault pulse, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
      access_fault <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rdata <= next_rdata;
      access_fault <= ((acc.wr || acc.rd) && refused) || tbit_clear;
    end
  end

  crf_mask #(
    .PW (PW)
  ) u_mask (
    .priority_mask_bit       (priority_mask_bit),
    .fault_mask_bit          (fault_mask_bit),
    .base_priority_threshold (base_priority_threshold),
    .req                     (req),
    .allowed                 (next_allowed)
  );

  // registered state views
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      req_allowed <= 1'b0;
      instruction_pointer_out <= RST_WORD;
      stack_pointer_out <= RST_WORD;
      status_word_out <= RST_WORD;
      handler_mode <= 1'b0;
      user_level <= 1'b0;
    end
    else if (clk_en)
    begin
      req_allowed <= next_allowed;
      instruction_pointer_out <= instruction_pointer;
      stack_pointer_out <= use_process_stack ? process_stack_pointer : main_stack_pointer;
      status_word_out <= status_word;
      handler_mode <= in_handler;
      user_level <= is_user;
    end
  end
endmodule

//--- verilog/crf_mask.sv
// crf_mask: decides whether a pending exception may be taken.
// assumes mask state comes from flops; purely combinational.
`timescale 1ns/1ns
module crf_mask #(
  parameter int PW = crf_pkg::PRIO_W
) (
  // mask state
  input  wire logic          priority_mask_bit,
  input  wire logic          fault_mask_bit,
  input  wire logic [PW-1:0] base_priority_threshold,
  // candidate exception
  input  wire crf_pkg::crf_req_t req,
  // verdict
  output logic               allowed
);
  import crf_pkg::*;

  logic base_ok;

  always_comb
  begin
    base_ok = (base_priority_threshold == '0) || (req.prio < base_priority_threshold);
    if (!req.valid)
      allowed = 1'b0;
    else if (req.nmi)
      allowed = 1'b1;
    else if (req.hard_fault)
      allowed = !fault_mask_bit;
    else
      allowed = !priority_mask_bit && !fault_mask_bit && base_ok;
  end
endmodule

//--- verilog/crf_pkg.sv
// crf_pkg: constants and carrier types for the core register file.
// assumes a single 32-bit core clock domain and a 5-bit register index.
package crf_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int PRIO_W = 9;
  localparam int NUM_GPR = 13;

  // register index map
  localparam logic [ADDR_W-1:0] IDX_GPR_LAST   = 5'h0C;
  localparam logic [ADDR_W-1:0] IDX_HIGH_FIRST = 5'h08;
  localparam logic [ADDR_W-1:0] IDX_STACK      = 5'h0D;
  localparam logic [ADDR_W-1:0] IDX_RETURN     = 5'h0E;
  localparam logic [ADDR_W-1:0] IDX_IPTR       = 5'h0F;
  localparam logic [ADDR_W-1:0] IDX_STATUS     = 5'h10;
  localparam logic [ADDR_W-1:0] IDX_APP_VIEW   = 5'h11;
  localparam logic [ADDR_W-1:0] IDX_INT_VIEW   = 5'h12;
  localparam logic [ADDR_W-1:0] IDX_EXEC_VIEW  = 5'h13;
  localparam logic [ADDR_W-1:0] IDX_PRI_MASK   = 5'h14;
  localparam logic [ADDR_W-1:0] IDX_FAULT_MASK = 5'h15;
  localparam logic [ADDR_W-1:0] IDX_BASE_PRI   = 5'h16;
  localparam logic [ADDR_W-1:0] IDX_MODE_CTRL  = 5'h17;
  localparam logic [ADDR_W-1:0] IDX_MAIN_STACK = 5'h18;
  localparam logic [ADDR_W-1:0] IDX_PROC_STACK = 5'h19;

  // status word field positions
  localparam int APP_LO  = 27;
  localparam int APP_HI  = 31;
  localparam int INT_LO  = 0;
  localparam int INT_HI  = 8;
  localparam int EXA_LO  = 10;
  localparam int EXA_HI  = 15;
  localparam int EXB_LO  = 25;
  localparam int EXB_HI  = 26;
  localparam int TBIT    = 24;
  localparam int SP_ALIGN_BITS = 2;

  // mode control bits
  localparam int CTRL_USER  = 0;
  localparam int CTRL_ALT_STACK = 1;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD   = 32'h0000_0000;
  localparam logic [1:0]        RST_CTRL   = 2'h0;
  localparam logic [PRIO_W-1:0] RST_BASE_PRIORITY_THRESHOLD = 9'h000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic              narrow;
    logic              narrow_hi_ok;
  } crf_acc_t;

  typedef struct packed {
    logic              valid;
    logic [PRIO_W-1:0] prio;
    logic              nmi;
    logic              hard_fault;
  } crf_req_t;
endpackage
